// *** rtl/cca_pkg.sv ***
// constants of the counter array compare block
package cca_pkg;

	// ----------------------------------------------------------------
	// geometry
	// ----------------------------------------------------------------
	localparam int         CCA_NUM_MOD = 5;
	localparam int         CCA_BYTE_W  = 8;
	localparam int         CCA_CNT_W   = 16;

	// ----------------------------------------------------------------
	// register addresses
	// ----------------------------------------------------------------
	localparam logic [7:0] CCA_ADDR_CNT_LO = 8'hf9;
	localparam logic [7:0] CCA_ADDR_CNT_HI = 8'hfa;
	localparam logic [7:0] CCA_ADDR_VAL_LO [CCA_NUM_MOD] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd};
	localparam logic [7:0] CCA_ADDR_VAL_HI [CCA_NUM_MOD] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe};

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  CCA_RST_BYTE = 8'h00;
	localparam logic [15:0] CCA_RST_CNT  = 16'h0000;
	localparam logic        CCA_RST_PIN  = 1'b1;
	localparam logic [7:0]  CCA_RD_NONE  = 8'h00;

	// ----------------------------------------------------------------
	// module operating modes, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		CCA_M_IDLE   = 5'b00001,
		CCA_M_TOGGLE = 5'b00010,
		CCA_M_FREQ   = 5'b00100,
		CCA_M_PWM8   = 5'b01000,
		CCA_M_PWM16  = 5'b10000
	} cca_mode_t;

endpackage

// *** rtl/cca_val_if.sv ***
// link between the top and one module value holder
`timescale 1ns/1ps
`default_nettype none
interface cca_val_if;
	logic [7:0] wdata;     // write byte
	logic       wr_lo;     // write low value byte
	logic       wr_hi;     // write high value byte
	logic       freq_step; // advance low byte by high byte
	logic       reload;    // copy high byte into low byte
	logic [7:0] val_lo;    // held low byte
	logic [7:0] val_hi;    // held high byte

	modport ctl (
		output wdata, wr_lo, wr_hi, freq_step, reload,
		input  val_lo, val_hi
	);
	modport unit (
		input  wdata, wr_lo, wr_hi, freq_step, reload,
		output val_lo, val_hi
	);
endinterface
`default_nettype wire

// *** rtl/cca_value.sv ***
// capture/compare value holder of one module
`timescale 1ns/1ps
`default_nettype none
module cca_value (
	input  wire logic  clk,   // system clock
	input  wire logic  rst_n, // synchronous reset, low active
	cca_val_if.unit    vif    // value access
);
	logic [7:0] lo_q;
	logic [7:0] hi_q;

	// ----------------------------------------------------------------
	// low byte: software write, then frequency step, then reload
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lo_q <= cca_pkg::CCA_RST_BYTE;
		end else if (vif.wr_lo) begin
			lo_q <= vif.wdata;
		end else if (vif.freq_step) begin
			lo_q <= lo_q + hi_q;
		end else if (vif.reload) begin
			lo_q <= hi_q;
		end
	end

	// high byte: software write only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hi_q <= cca_pkg::CCA_RST_BYTE;
		end else if (vif.wr_hi) begin
			hi_q <= vif.wdata;
		end
	end

	assign vif.val_lo = lo_q;
	assign vif.val_hi = hi_q;
endmodule
`default_nettype wire

// *** rtl/cca_top.sv ***
// counter array: 16-bit counter, five compare modules, byte registers
// Function
// - pwm enable drives waveform on output pin
// - wide select picks 16-bit, else 8-bit pwm
// - pwm plus toggle gives frequency output mode
// - counter bytes at 0xf9 and 0xfa
// - module low value bytes readable and writable
// - module high value bytes readable and writable
// - toggle mode inverts pin on each match
`timescale 1ns/1ps
`default_nettype none
module cca_top (
	input  wire logic       CLK,       // system clock, 40 MHz
	input  wire logic       RST_N,     // synchronous reset, low active
	input  wire logic [7:0] SFR_ADDR,  // register address
	input  wire logic       SFR_WR,    // register write strobe
	input  wire logic       SFR_RD,    // register read strobe
	input  wire logic [7:0] SFR_WDATA, // register write data
	output logic      [7:0] SFR_RDATA, // register read data, next cycle
	input  wire logic       COUNT_EN,  // counter advance tick
	input  wire logic [4:0] PWM_EN,    // pwm enable bit per module
	input  wire logic [4:0] WIDE_PWM,  // wide pwm select per module
	input  wire logic [4:0] TOG_EN,    // toggle enable bit per module
	input  wire logic [4:0] FLAG_IE,   // flag interrupt enable per module
	input  wire logic [4:0] CCF_CLR,   // clear strobe for each flag
	output logic      [4:0] MOD_OUT,   // module output pins
	output logic      [4:0] CCF,       // capture/compare flags
	output logic      [4:0] IRQ        // interrupt request per module
);

	// ----------------------------------------------------------------
	// shared state
	// ----------------------------------------------------------------
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	logic        moved_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic [4:0]  pin_q;
	logic [4:0]  ccf_q;
	logic [4:0]  ccf_d;
	logic [4:0]  irq_q;
	logic [7:0]  val_lo [cca_pkg::CCA_NUM_MOD];
	logic [7:0]  val_hi [cca_pkg::CCA_NUM_MOD];
	logic        wr_cnt_lo;
	logic        wr_cnt_hi;

	// one value link per module; the holders own the value bytes
	// and apply the software writes before any mode update
	cca_val_if vif [cca_pkg::CCA_NUM_MOD] ();

	// ----------------------------------------------------------------
	// register bus decode
	// ----------------------------------------------------------------

	// a write to an unmapped address matches no strobe and is dropped
	// counter byte write strobes
	// counter byte decode
	assign wr_cnt_lo = SFR_WR && (SFR_ADDR == cca_pkg::CCA_ADDR_CNT_LO);
	assign wr_cnt_hi = SFR_WR && (SFR_ADDR == cca_pkg::CCA_ADDR_CNT_HI);

	// read multiplexer, unmapped addresses read zero
	always_comb begin
		rdata_d = cca_pkg::CCA_RD_NONE;
		if (SFR_ADDR == cca_pkg::CCA_ADDR_CNT_LO) begin
			rdata_d = cnt_q[7:0];
		end
		if (SFR_ADDR == cca_pkg::CCA_ADDR_CNT_HI) begin
			rdata_d = cnt_q[15:8];
		end
		for (int i = 0; i < cca_pkg::CCA_NUM_MOD; i++) begin
			if (SFR_ADDR == cca_pkg::CCA_ADDR_VAL_LO[i]) begin
				rdata_d = val_lo[i];
			end
			if (SFR_ADDR == cca_pkg::CCA_ADDR_VAL_HI[i]) begin
				rdata_d = val_hi[i];
			end
		end
	end

	// registered read data costs one cycle of latency but gives the bus a
	// flop-driven output and keeps the read path off the match logic
	// read data is captured on the read strobe and held otherwise
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rdata_q <= cca_pkg::CCA_RD_NONE;
		end else if (SFR_RD) begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// counter
	// ----------------------------------------------------------------

	// next count: byte writes beat the advance tick
	// a byte write replaces only its own byte; the other byte still follows
	// the tick, so a carry out of the low byte is not lost
	always_comb begin
		cnt_d = cnt_q;
		if (COUNT_EN) begin
			cnt_d = cnt_q + 16'h0001;
		end
		if (wr_cnt_lo) begin
			cnt_d[7:0] = SFR_WDATA;
		end
		if (wr_cnt_hi) begin
			cnt_d[15:8] = SFR_WDATA;
		end
	end

	// counter register
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			cnt_q <= cca_pkg::CCA_RST_CNT;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// marks a cycle in which the counter holds a freshly advanced value;
	// compares act only then, so a stalled counter cannot retrigger them
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			moved_q <= 1'b0;
		end else begin
			moved_q <= COUNT_EN && !wr_cnt_lo && !wr_cnt_hi;
		end
	end

	// ----------------------------------------------------------------
	// compare modules
	// ----------------------------------------------------------------
	for (genvar g = 0; g < cca_pkg::CCA_NUM_MOD; g++) begin : g_mod
		cca_pkg::cca_mode_t mode;
		logic               match16;
		logic               match8;
		logic               wrap8;
		logic               wrap16;
		logic               hit;
		logic               pin_d;

		// value holder of this module
		cca_value u_value (
			.clk   (CLK),
			.rst_n (RST_N),
			.vif   (vif[g])
		);

		// value byte writes
		// low value decode
		assign vif[g].wr_lo = SFR_WR && (SFR_ADDR == cca_pkg::CCA_ADDR_VAL_LO[g]);
		assign vif[g].wr_hi = SFR_WR && (SFR_ADDR == cca_pkg::CCA_ADDR_VAL_HI[g]);
		assign vif[g].wdata = SFR_WDATA;
		assign val_lo[g]    = vif[g].val_lo;
		assign val_hi[g]    = vif[g].val_hi;

		// mode from the enable bits
		// frequency output takes precedence since it needs both bits set
		always_comb begin
			mode = cca_pkg::CCA_M_IDLE;
			if (PWM_EN[g] && TOG_EN[g]) begin
				mode = cca_pkg::CCA_M_FREQ;
			end else if (PWM_EN[g]) begin
				mode = WIDE_PWM[g] ? cca_pkg::CCA_M_PWM16 : cca_pkg::CCA_M_PWM8;
			end else if (TOG_EN[g]) begin
				mode = cca_pkg::CCA_M_TOGGLE;
			end
		end

		// counter against value, only on a fresh count
		// the 8-bit compares look at the low byte only, so they recur every
		// 256 ticks whatever the high byte holds
		assign match16 = moved_q && (cnt_q == {val_hi[g], val_lo[g]});
		assign match8  = moved_q && (cnt_q[7:0] == val_lo[g]);
		assign wrap8   = moved_q && (cnt_q[7:0] == 8'h00);
		assign wrap16  = moved_q && (cnt_q == 16'h0000);

		// match event that sets the flag, per mode
		// the flag follows the compare that drives the pin in each mode but idle, where the pin holds and the full match sets it
		always_comb begin
			unique case (mode)
				cca_pkg::CCA_M_FREQ,
				cca_pkg::CCA_M_PWM8: begin
					hit = match8;
				end
				cca_pkg::CCA_M_IDLE,
				cca_pkg::CCA_M_TOGGLE,
				cca_pkg::CCA_M_PWM16: begin
					hit = match16;
				end
				default: begin
					hit = 1'b0;
				end
			endcase
		end

		// value updates asked of the holder
		// a software write to the same byte wins inside the holder
		// step toggle point
		assign vif[g].freq_step = (mode == cca_pkg::CCA_M_FREQ) && match8;
		assign vif[g].reload    = (mode == cca_pkg::CCA_M_PWM8) && wrap8 && !match8;

		// next pin level per mode
		always_comb begin
			pin_d = pin_q[g];
			unique case (mode)
				cca_pkg::CCA_M_TOGGLE: begin
					if (match16) begin
						pin_d = !pin_q[g];
					end
				end
				cca_pkg::CCA_M_FREQ: begin
					if (match8) begin
						pin_d = !pin_q[g];
					end
				end
				cca_pkg::CCA_M_PWM8: begin
					if (match8) begin
						pin_d = 1'b0;
					end else if (wrap8) begin
						pin_d = 1'b1;
					end
				end
				cca_pkg::CCA_M_PWM16: begin
					if (match16) begin
						pin_d = 1'b0;
					end else if (wrap16) begin
						pin_d = 1'b1;
					end
				end
				cca_pkg::CCA_M_IDLE: begin
					pin_d = pin_q[g];
				end
				default: begin
					pin_d = pin_q[g];
				end
			endcase
		end

		// pin register
		// pins reset high, the level a pwm output shows before its first match
		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				pin_q[g] <= cca_pkg::CCA_RST_PIN;
			end else begin
				pin_q[g] <= pin_d;
			end
		end

		// flag: a match in the clearing cycle keeps the flag set
		// set beats clear so that an event landing on the clear is not lost
		always_comb begin
			ccf_d[g] = ccf_q[g];
			if (CCF_CLR[g]) begin
				ccf_d[g] = 1'b0;
			end
			if (hit) begin
				ccf_d[g] = 1'b1;
			end
		end

		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				ccf_q[g] <= 1'b0;
			end else begin
				ccf_q[g] <= ccf_d[g];
			end
		end

		// request follows the flag in the same edge when enabled
		// built from the next flag value so the request never trails the flag
		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				irq_q[g] <= 1'b0;
			end else begin
				irq_q[g] <= ccf_d[g] && FLAG_IE[g];
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign SFR_RDATA = rdata_q;
	assign MOD_OUT   = pin_q;
	assign CCF       = ccf_q;
	assign IRQ       = irq_q;

endmodule
`default_nettype wire

// *** tb/cca_top_properties.sv ***
// port checks of the counter array
`timescale 1ns/1ps
`default_nettype none
module cca_top_properties (
	input wire logic       CLK,       // clock
	input wire logic       RST_N,     // reset
	input wire logic [7:0] SFR_ADDR,  // address
	input wire logic       SFR_WR,    // write
	input wire logic       SFR_RD,    // read
	input wire logic [7:0] SFR_WDATA, // wdata
	input wire logic [7:0] SFR_RDATA, // rdata
	input wire logic       COUNT_EN,  // tick
	input wire logic [4:0] PWM_EN,    // pwm
	input wire logic [4:0] TOG_EN,    // toggle
	input wire logic [4:0] FLAG_IE,   // irq enable
	input wire logic [4:0] CCF_CLR,   // clear
	input wire logic [4:0] MOD_OUT,   // pins
	input wire logic [4:0] CCF,       // flags
	input wire logic [4:0] IRQ        // requests
);
	// --------
	// checks
	// --------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_N);
	logic cnt_a;
	logic map_a;
	// address decode
	assign cnt_a = SFR_ADDR inside {8'hf9, 8'hfa};
	assign map_a = SFR_ADDR inside {[8'he9:8'hee], [8'hf9:8'hfe]};
	a_cnt_rdback: assert property (SFR_RD && !SFR_WR && $past(SFR_WR) && $past(RST_N)
		&& SFR_ADDR == $past(SFR_ADDR) && cnt_a |=> SFR_RDATA == $past(SFR_WDATA, 2))
		else $error("counter byte readback wrong");
	a_val_rdback: assert property (SFR_RD && !SFR_WR && $past(SFR_WR) && $past(RST_N)
		&& SFR_ADDR == $past(SFR_ADDR) && map_a && !cnt_a
		|=> SFR_RDATA == $past(SFR_WDATA, 2))
		else $error("value byte readback wrong");
	a_rd_unmapped: assert property (SFR_RD && !map_a |=> SFR_RDATA == 8'h00)
		else $error("unmapped read not zero");
	a_rd_hold: assert property (!SFR_RD |=> $stable(SFR_RDATA))
		else $error("read data moved without read");
	a_irq_gate: assert property ($stable(FLAG_IE) && $past(RST_N)
		|-> IRQ == (CCF & FLAG_IE))
		else $error("request not flag and enable");
	a_irq_flag: assert property ((IRQ & ~CCF) == 5'h00)
		else $error("request without flag");
	a_flag_sticky: assert property ($past(RST_N)
		|-> ($past(CCF) & ~$past(CCF_CLR) & ~CCF) == 5'h00)
		else $error("flag dropped without clear");
	a_pin_idle: assert property ($stable(PWM_EN) && $stable(TOG_EN) && $past(RST_N)
		|-> ((MOD_OUT ^ $past(MOD_OUT)) & ~PWM_EN & ~TOG_EN) == 5'h00)
		else $error("idle module pin moved");
	a_no_event: assert property (!COUNT_EN
		|-> ##2 ($stable(MOD_OUT) && (CCF & ~$past(CCF)) == 5'h00))
		else $error("event without counter tick");
endmodule
bind cca_top cca_top_properties cca_top_properties_i (.CLK(CLK), .RST_N(RST_N),
	.SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_WDATA(SFR_WDATA),
	.SFR_RDATA(SFR_RDATA), .COUNT_EN(COUNT_EN), .PWM_EN(PWM_EN), .TOG_EN(TOG_EN),
	.FLAG_IE(FLAG_IE), .CCF_CLR(CCF_CLR), .MOD_OUT(MOD_OUT), .CCF(CCF), .IRQ(IRQ));
`default_nettype wire

// *** tb/cca_sw_model.sv ***
// software side: byte accesses to the registers
`timescale 1ns/1ps
`default_nettype none
module cca_sw_model (
	input  wire logic       clk,   // clock
	output logic      [7:0] addr,  // address
	output logic            wr,    // write
	output logic            rd,    // read
	output logic      [7:0] wdata, // wdata
	input  wire logic [7:0] rdata  // rdata
);
	// --------
	// access
	// --------
	// one write pulse, data flipped once released
	task automatic put(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		wdata <= ~d;
	endtask
	// called on an edge: read raised there, data taken at the edge after the answer
	task automatic get(input logic [7:0] a, output logic [7:0] d);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(posedge clk);
		d = rdata;
	endtask
	// idle bus
	initial begin
		addr  = 8'h00;
		wr    = 1'b0;
		rd    = 1'b0;
		wdata = 8'h00;
	end
endmodule
`default_nettype wire

// *** tb/cca_top_tb.sv ***
// self-checking bench of the counter array
`timescale 1ns/1ps
`default_nettype none
module cca_top_tb;
	// --------
	// bench
	// --------
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        wr, rd, cnt_en, p;
	logic [7:0]  addr, wdata, rdata, rv, b;
	logic [4:0]  pwm, wide, tog, ie, clr, pin, ccf, irq;
	logic [15:0] v;
	int          miscompares = 0;
	int          tests_run = 0;
	int          cyc = 0;
	int          seed = 32'h27c7;
	logic [7:0]  ra [12] = '{8'hf9, 8'hfa, 8'hfb, 8'hfc, 8'he9, 8'hea,
		8'heb, 8'hec, 8'hed, 8'hee, 8'hfd, 8'hfe};
	// clock
	always #12.5 clk = ~clk;
	cca_sw_model cca_sw_model_i (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
		.wdata(wdata), .rdata(rdata));
	cca_top cca_top_i (.CLK(clk), .RST_N(rst_n), .SFR_ADDR(addr), .SFR_WR(wr),
		.SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata), .COUNT_EN(cnt_en),
		.PWM_EN(pwm), .WIDE_PWM(wide), .TOG_EN(tog), .FLAG_IE(ie), .CCF_CLR(clr),
		.MOD_OUT(pin), .CCF(ccf), .IRQ(irq));
	// compare and count
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// expected low byte after one frequency step
	function automatic logic [7:0] step_lo(input logic [15:0] x);
		return x[7:0] + x[15:8];
	endfunction
	// verdict
	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// value bytes of module m
	task automatic wv(input int m, input logic [15:0] x);
		cca_sw_model_i.put(ra[2 + 2 * m], x[7:0]);
		cca_sw_model_i.put(ra[3 + 2 * m], x[15:8]);
	endtask
	// mode {pwm, wide, toggle} on module m, random irq enables
	task automatic md(input int m, input logic [2:0] k);
		@(posedge clk);
		pwm  <= 5'(k[2]) << m;
		wide <= 5'(k[1]) << m;
		tog  <= 5'(k[0]) << m;
		ie   <= 5'($random(seed));
	endtask
	// load counter, one tick, let the compare land
	task automatic run(input logic [15:0] c);
		cca_sw_model_i.put(8'hf9, c[7:0]);
		cca_sw_model_i.put(8'hfa, c[15:8]);
		cnt_en <= 1'b1;
		@(posedge clk);
		cnt_en <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task automatic flush();
		@(posedge clk);
		clr <= 5'h1f;
		@(posedge clk);
		clr <= 5'h00;
		@(posedge clk);
		chk("clr", 16'h0000, {6'h00, ccf, irq});
	endtask
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			test_done();
		end
	end
	initial begin
		{cnt_en, pwm, wide, tog, ie, clr} = '0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		chk("outs", 16'h001f, {1'b0, irq, ccf, pin});
		foreach (ra[i]) begin
			cca_sw_model_i.get(ra[i], rv);
			chk("rst", 16'h0000, {8'h00, rv});
			b = 8'($random(seed));
			cca_sw_model_i.put(ra[i], b);
			cca_sw_model_i.get(ra[i], rv);
			chk("reg", {8'h00, b}, {8'h00, rv});
		end
		cca_sw_model_i.put(8'hf8, 8'h5a);
		cca_sw_model_i.get(8'hf8, rv);
		chk("unmap", 16'h0000, {8'h00, rv});
		$display("test registers done");
		for (int m = 0; m < 5; m++) begin
			v = 16'($random(seed)) | 16'h0201;
			// idle module: pin holds, full match still sets flag
			md(m, 3'b000);
			wv(m, v);
			p = pin[m];
			run(v - 16'h0001);
			chk("idle", {14'h0, p, 1'b1}, {14'h0, pin[m], ccf[m]});
			flush();
			md(m, 3'b001);
			wv(m, v);
			p = pin[m];
			run(v - 16'h0001);
			chk("tog", {14'h0, ~p, 1'b1}, {14'h0, pin[m], ccf[m]});
			chk("irq", {15'h0, ie[m]}, {15'h0, irq[m]});
			flush();
			md(m, 3'b100);
			run({8'h00, v[7:0] - 8'h01});
			chk("pwm8m", 16'h0000, {15'h0, pin[m]});
			run(16'h00ff);
			cca_sw_model_i.get(ra[2 + 2 * m], rv);
			chk("pwm8w", {7'h0, 1'b1, v[15:8]}, {7'h0, pin[m], rv});
			md(m, 3'b110);
			wv(m, v);
			run({8'h00, v[7:0] - 8'h01});
			chk("pwm16l", 16'h0001, {15'h0, pin[m]});
			run(v - 16'h0001);
			chk("pwm16m", 16'h0000, {15'h0, pin[m]});
			run(16'hffff);
			chk("pwm16z", 16'h0001, {15'h0, pin[m]});
			md(m, 3'b101);
			wv(m, v);
			p = pin[m];
			run({8'h00, v[7:0] - 8'h01});
			cca_sw_model_i.get(ra[2 + 2 * m], rv);
			chk("freq", {7'h0, ~p, step_lo(v)}, {7'h0, pin[m], rv});
			flush();
		end
		$display("test modes done");
		test_done();
	end
endmodule
`default_nettype wire
